// ### core/pds_pkg.sv
package pds_pkg;
  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int          ADDR_W       = 24;
  localparam int          WORD_W       = 16;
  localparam int          PAGE_W       = 10;
  localparam int          PAGE_PROG_BIT = 9;
  localparam int          ADDR_TOP_BIT  = 15;
  localparam logic [9:0]  PAGE_RESET   = 10'h001;
  localparam logic [9:0]  PAGE_ZERO    = 10'h000;
  localparam logic [15:0] SP_RESET     = 16'h1000;
  localparam logic [15:0] SP_STEP      = 16'h0002;
  localparam logic [7:0]  BASE_UPPER   = 8'h00;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0]  OFF_PAGE     = 8'h00;
  localparam logic [7:0]  OFF_SP       = 8'h04;
  localparam logic [7:0]  OFF_CTRL     = 8'h08;
  localparam logic [7:0]  OFF_STAT     = 8'h0C;
  localparam logic [7:0]  OFF_MASK     = 8'h10;
  localparam int          CTRL_FRAME_BIT = 0;
  localparam int          EV_ADDR_ERR    = 0;
  localparam int          EV_PROG_WR     = 1;
  localparam int          EV_W         = 2;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_PC_HI = 1'b1} pds_stk_state_t;
  typedef enum logic [1:0] {PC_NONE = 2'b00, PC_CALL = 2'b01, PC_EXC = 2'b10} pds_pc_kind_t;

  typedef struct packed {
    logic        valid;
    logic        viaSp;
    logic        viaFp;
    logic        write;
    logic [15:0] effAddr;
  } pds_acc_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        prog;
    logic [23:0] addr;
  } pds_mem_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pds_stk_t;
endpackage

// ### core/pds_unit.sv
`timescale 1ns/1ps
module pds_unit (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire pds_pkg::pds_acc_t     accReq,
  output pds_pkg::pds_mem_t          memReq,
  output logic                       addrErrTrap,
  input  wire logic                  cpuSpWe,
  input  wire logic [15:0]           cpuSpData,
  input  wire logic                  stkPush,
  input  wire logic [15:0]           stkPushData,
  input  wire logic                  stkPop,
  input  wire pds_pkg::pds_pc_kind_t pcPush,
  input  wire logic [22:0]           pcValue,
  input  wire logic [7:0]            statusLow,
  output pds_pkg::pds_stk_t          stkReq,
  output logic                       stkBusy,
  output logic                       irq
);

  // ****************************************
  // state
  // ****************************************
  logic [9:0]                 pageReg;
  logic [15:0]                spReg;
  logic                       frameFlagReg;
  logic [1:0]                 statReg;
  logic [1:0]                 maskReg;
  logic [1:0]                 evPulse;
  pds_pkg::pds_stk_state_t    stkState;
  logic [15:0]                pcHiWord;
  logic                       awHeld;
  logic                       wHeld;
  logic [7:0]                 awAddrReg;
  logic [31:0]                wDataReg;
  logic [3:0]                 wStrbReg;
  logic                       wrDo;
  logic                       rdDo;
  logic                       statRdClr;
  logic [1:0]                 statNext;
  logic [1:0]                 maskNext;

  // ****************************************
  // helpers
  // ****************************************
  // upper pc stack word; the exception form carries the status low byte
  function automatic logic [15:0] pc_hi_word(input pds_pkg::pds_pc_kind_t kind, input logic [6:0] pcHi,
                                               input logic [7:0] statLow);
    if (kind == pds_pkg::PC_EXC) begin
      pc_hi_word = {statLow, 1'b0, pcHi};
    end else begin
      pc_hi_word = {9'h000, pcHi};
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == pds_pkg::OFF_PAGE) || (a == pds_pkg::OFF_SP) || (a == pds_pkg::OFF_CTRL) ||
             (a == pds_pkg::OFF_STAT) || (a == pds_pkg::OFF_MASK);
  endfunction

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  assign wrDo = awHeld && wHeld && !s_axi_bvalid;

  // address and data are caught separately, so either may arrive first
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddrReg     <= 8'h00;
      wDataReg      <= 32'h00000000;
      wStrbReg      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pds_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && !wrDo;
      s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready) && !wrDo;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld    <= 1'b1;
        awAddrReg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld    <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
      end
      if (wrDo) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddrReg) ? pds_pkg::RESP_OKAY : pds_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  assign rdDo      = s_axi_arvalid && s_axi_arready;
  assign statRdClr = rdDo && (s_axi_araddr == pds_pkg::OFF_STAT);

  // one read in flight; arready drops while the answer stands
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= pds_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rdDo;
      if (rdDo) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? pds_pkg::RESP_OKAY : pds_pkg::RESP_SLVERR;
        if (s_axi_araddr == pds_pkg::OFF_PAGE) begin
          s_axi_rdata <= {22'h000000, pageReg};
        end else if (s_axi_araddr == pds_pkg::OFF_SP) begin
          s_axi_rdata <= {16'h0000, spReg};
        end else if (s_axi_araddr == pds_pkg::OFF_CTRL) begin
          s_axi_rdata <= {31'h00000000, frameFlagReg};
        end else if (s_axi_araddr == pds_pkg::OFF_STAT) begin
          s_axi_rdata <= {30'h00000000, statReg | evPulse};
        end else if (s_axi_araddr == pds_pkg::OFF_MASK) begin
          s_axi_rdata <= {30'h00000000, maskReg};
        end else begin
          s_axi_rdata <= 32'h00000000;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // data page register
  // ****************************************
  // a zero write is dropped so page zero never reaches the upper window
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pageReg <= pds_pkg::PAGE_RESET;
    end else if (wrDo && awAddrReg == pds_pkg::OFF_PAGE && wStrbReg[0] && wStrbReg[1]) begin
      if (wDataReg[9:0] != pds_pkg::PAGE_ZERO) begin
        pageReg <= wDataReg[9:0];
      end
    end
  end

  // control and mask, whole low byte lane only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      frameFlagReg <= 1'b0;
      maskReg      <= 2'h0;
    end else if (wrDo && wStrbReg[0]) begin
      if (awAddrReg == pds_pkg::OFF_CTRL) begin
        frameFlagReg <= wDataReg[pds_pkg::CTRL_FRAME_BIT];
      end else if (awAddrReg == pds_pkg::OFF_MASK) begin
        maskReg <= wDataReg[1:0];
      end
    end
  end

  // ****************************************
  // address generation
  // ****************************************
  // one registered stage; the memory sees the decision a cycle later
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      memReq      <= '0;
      addrErrTrap <= 1'b0;
      evPulse     <= 2'h0;
    end else begin
      memReq      <= '0;
      addrErrTrap <= 1'b0;
      evPulse     <= 2'h0;
      if (accReq.valid) begin
        if (!accReq.effAddr[pds_pkg::ADDR_TOP_BIT] || accReq.viaSp || (accReq.viaFp && frameFlagReg)) begin
          memReq <= '{valid: 1'b1, write: accReq.write, prog: 1'b0,
                      addr: {pds_pkg::BASE_UPPER, accReq.effAddr}};
        end else if (pageReg == pds_pkg::PAGE_ZERO) begin
          addrErrTrap                  <= 1'b1;
          evPulse[pds_pkg::EV_ADDR_ERR] <= 1'b1;
        end else if (pageReg[pds_pkg::PAGE_PROG_BIT]) begin
          if (accReq.write) begin
            evPulse[pds_pkg::EV_PROG_WR] <= 1'b1;
          end else begin
            memReq <= '{valid: 1'b1, write: 1'b0, prog: 1'b1,
                        addr: {pageReg[8:0], accReq.effAddr[14:0]}};
          end
        end else begin
          memReq <= '{valid: 1'b1, write: accReq.write, prog: 1'b0,
                      addr: {pageReg[8:0], accReq.effAddr[14:0]}};
        end
      end
    end
  end

  // ****************************************
  // software stack
  // ****************************************
  // a cpu write to the pointer wins over stack traffic in the same idle cycle; it is dropped while the second pc word goes out
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      spReg    <= pds_pkg::SP_RESET;
      stkState <= pds_pkg::ST_IDLE;
      stkReq   <= '0;
      stkBusy  <= 1'b0;
      pcHiWord <= 16'h0000;
    end else begin
      stkReq <= '0;
      case (stkState)
        pds_pkg::ST_IDLE: begin
          if (cpuSpWe) begin
            spReg <= {cpuSpData[15:1], 1'b0};
          end else if (wrDo && awAddrReg == pds_pkg::OFF_SP && wStrbReg[0] && wStrbReg[1]) begin
            spReg <= {wDataReg[15:1], 1'b0};
          end else if (pcPush != pds_pkg::PC_NONE) begin
            stkReq   <= '{valid: 1'b1, write: 1'b1, addr: spReg, wdata: pcValue[15:0]};
            spReg    <= spReg + pds_pkg::SP_STEP;
            pcHiWord <= pc_hi_word(pcPush, pcValue[22:16], statusLow);
            stkBusy  <= 1'b1;
            stkState <= pds_pkg::ST_PC_HI;
          end else if (stkPush) begin
            stkReq <= '{valid: 1'b1, write: 1'b1, addr: spReg, wdata: stkPushData};
            spReg  <= spReg + pds_pkg::SP_STEP;
          end else if (stkPop) begin
            stkReq <= '{valid: 1'b1, write: 1'b0, addr: spReg - pds_pkg::SP_STEP, wdata: 16'h0000};
            spReg  <= spReg - pds_pkg::SP_STEP;
          end
        end
        pds_pkg::ST_PC_HI: begin
          stkReq   <= '{valid: 1'b1, write: 1'b1, addr: spReg, wdata: pcHiWord};
          spReg    <= spReg + pds_pkg::SP_STEP;
          stkBusy  <= 1'b0;
          stkState <= pds_pkg::ST_IDLE;
        end
        default: begin
          stkState <= pds_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // events and interrupt
  // ****************************************
  // next status and mask, so irq never lags a mask write by a cycle
  assign statNext = (statRdClr ? 2'h0 : statReg) | evPulse;
  assign maskNext = (wrDo && wStrbReg[0] && awAddrReg == pds_pkg::OFF_MASK) ? wDataReg[1:0] : maskReg;

  // a read clears, but an event in the same cycle survives it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      statReg <= 2'h0;
      irq     <= 1'b0;
    end else begin
      statReg <= statNext;
      irq     <= |(statNext & maskNext);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_prog_addr_form: assert property (@(posedge clock) disable iff (!nrst)
    accReq.valid && accReq.effAddr[15] && !accReq.viaSp && !accReq.viaFp && pageReg[9] && !accReq.write
    |=> memReq.valid && memReq.prog && memReq.addr == {$past(pageReg[8:0]), $past(accReq.effAddr[14:0])})
    else $error("program space address not formed from page and address");

  a_prog_no_write: assert property (@(posedge clock) disable iff (!nrst)
    memReq.prog |-> !memReq.write && $past(pageReg[pds_pkg::PAGE_PROG_BIT]))
    else $error("program space written or reached below page 0x200");

  a_low_half_direct: assert property (@(posedge clock) disable iff (!nrst)
    accReq.valid && !accReq.effAddr[15]
    |=> memReq.valid && !memReq.prog && memReq.addr == {8'h00, $past(accReq.effAddr)})
    else $error("low half of base space was paged");

  a_page_never_zero: assert property (@(posedge clock) disable iff (!nrst)
    pageReg != 10'h000)
    else $error("page register reached zero");

  a_page_zero_trap: assert property (@(posedge clock) disable iff (!nrst)
    accReq.valid && accReq.effAddr[15] && !accReq.viaSp && !(accReq.viaFp && frameFlagReg) && pageReg == 10'h000
    |=> addrErrTrap && !memReq.valid)
    else $error("page zero access did not trap");

  a_sp_aligned: assert property (@(posedge clock) disable iff (!nrst)
    !spReg[0] && !(stkReq.valid && stkReq.addr[0]))
    else $error("stack pointer misaligned");

  a_push_then_inc: assert property (@(posedge clock) disable iff (!nrst)
    stkState == pds_pkg::ST_IDLE && !cpuSpWe && !(wrDo && awAddrReg == pds_pkg::OFF_SP) && pcPush == pds_pkg::PC_NONE
    && stkPush |=> stkReq.write && stkReq.addr == $past(spReg) && spReg == $past(spReg) + 16'h0002)
    else $error("push order wrong");

  a_pop_pre_dec: assert property (@(posedge clock) disable iff (!nrst)
    stkState == pds_pkg::ST_IDLE && !cpuSpWe && !(wrDo && awAddrReg == pds_pkg::OFF_SP) && pcPush == pds_pkg::PC_NONE
    && !stkPush && stkPop |=> !stkReq.write && stkReq.valid && stkReq.addr == spReg)
    else $error("pop did not pre-decrement");

  a_pc_two_words: assert property (@(posedge clock) disable iff (!nrst)
    stkState == pds_pkg::ST_IDLE && !cpuSpWe && !(wrDo && awAddrReg == pds_pkg::OFF_SP) && pcPush == pds_pkg::PC_CALL
    |=> stkReq.wdata == $past(pcValue[15:0]) ##1 stkReq.valid && stkReq.wdata == {9'h000, $past(pcValue[22:16], 2)}
    && spReg == $past(spReg, 2) + 16'h0004)
    else $error("call push of pc wrong");

  a_irq_follows: assert property (@(posedge clock) disable iff (!nrst)
    irq == (|(statReg & maskReg)))
    else $error("interrupt does not follow unmasked status");

endmodule

// ### dv/pds_cpu_model.sv
`timescale 1ns/1ps
// ****************************************
// cpu core side of the unit
// ****************************************
module pds_cpu_model (
  input  wire logic             clock,
  output pds_pkg::pds_acc_t     accReq,
  output logic                  cpuSpWe,
  output logic [15:0]           cpuSpData,
  output logic                  stkPush,
  output logic [15:0]           stkPushData,
  output logic                  stkPop,
  output pds_pkg::pds_pc_kind_t pcPush,
  output logic [22:0]           pcValue,
  output logic [7:0]            statusLow
);
  // idle from time zero, no stray request before reset release
  initial begin
    accReq = '0;
    {cpuSpWe, cpuSpData, stkPush, stkPushData, stkPop} = '0;
    pcPush = pds_pkg::PC_NONE;
    {pcValue, statusLow} = '0;
  end

  // one-cycle access; upper pages only ever offered with address bit15 set
  task automatic access(input logic sp, input logic fp, input logic wr, input logic [15:0] effAddr);
    @(posedge clock);
    accReq <= '{1'b1, sp, fp, wr, effAddr};
    @(posedge clock);
    accReq.valid <= 1'b0;
  endtask

  // stack op: 0 pointer write, 1 push, 2 pop, 3 pc save; idle cycle after
  task automatic stack(input int op, input logic [22:0] v, input pds_pkg::pds_pc_kind_t k,
                       input logic [7:0] s);
    @(posedge clock);
    cpuSpWe <= (op == 0);
    cpuSpData <= v[15:0];
    stkPush <= (op == 1);
    stkPushData <= v[15:0];
    stkPop <= (op == 2);
    pcPush <= (op == 3) ? k : pds_pkg::PC_NONE;
    pcValue <= v;
    statusLow <= s;
    @(posedge clock);
    {cpuSpWe, stkPush, stkPop} <= 3'h0;
    pcPush <= pds_pkg::PC_NONE;
  endtask
endmodule

// ### dv/tb_paged_data_space_and_stack.sv
`timescale 1ns/1ps
module tb_paged_data_space_and_stack;
  logic                  clock = 0, nrst = 0;
  logic [7:0]            s_axi_awaddr = 0, s_axi_araddr = 0, statusLow;
  logic [31:0]           s_axi_wdata = 0, s_axi_rdata, r;
  logic [3:0]            s_axi_wstrb = 4'hF;
  logic                  s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic                  addrErrTrap, cpuSpWe, stkPush, stkPop, stkBusy, irq, frameOn, aP, wP, aT, wT;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic [15:0]           cpuSpData, stkPushData, sp, effAddr;
  logic [22:0]           pcValue;
  logic [9:0]            pg;
  logic [34:0]           e, rdQ[$];
  logic [1:0]            bQ[$];
  logic [25:0]           memQ[$];
  logic [32:0]           stkQ[$];
  pds_pkg::pds_acc_t     accReq;
  pds_pkg::pds_mem_t     memReq;
  pds_pkg::pds_stk_t     stkReq;
  pds_pkg::pds_pc_kind_t pcPush;
  int                    fails = 0, checks_done = 0, cycles = 0, seed = 64057, i, j;

  pds_unit uut (.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .accReq, .memReq, .addrErrTrap,
    .cpuSpWe, .cpuSpData, .stkPush, .stkPushData, .stkPop, .pcPush, .pcValue, .statusLow, .stkReq, .stkBusy, .irq);
  pds_cpu_model cpu (.clock, .accReq, .cpuSpWe, .cpuSpData, .stkPush, .stkPushData, .stkPop, .pcPush,
    .pcValue, .statusLow);

  always #10 clock = ~clock;

  task automatic check(input logic [34:0] seen, input logic [34:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // hang guard, the whole run needs a few hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test;
    end
  end

  // ****************************************
  // scoreboard
  // ****************************************
  // sampled mid-cycle so design updates of the edge have landed
  always @(negedge clock) begin
    if (memReq.valid === 1'b1)
      check({memReq.write, memReq.prog, memReq.addr}, memQ.size() ? memQ.pop_front() : 'x, "mem");
    if (stkReq.valid === 1'b1)
      check({stkReq.write, stkReq.addr, stkReq.write ? stkReq.wdata : 16'h0},
            stkQ.size() ? stkQ.pop_front() : 'x, "stack");
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      e = rdQ.pop_front();
      check({e[34], s_axi_rresp, e[34] ? s_axi_rdata : 32'h0}, e, "read");
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready) check(s_axi_bresp, bQ.pop_front(), "bresp");
    if (nrst && addrErrTrap !== 1'b0) check(addrErrTrap, 1'b0, "trap");
  end

  function automatic logic [34:0] ok(input logic [31:0] d);
    return {1'b1, pds_pkg::RESP_OKAY, d};
  endfunction

  // aw and w offered together, each released on its own take
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bQ.push_back(er);
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {aP, wP} = 2'b11;
    while (aP || wP) begin
      @(negedge clock);
      aT = aP && s_axi_awready === 1'b1;
      wT = wP && s_axi_wready === 1'b1;
      @(posedge clock);
      if (aT) {aP, s_axi_awvalid} <= 2'b00;
      if (wT) {wP, s_axi_wvalid} <= 2'b00;
    end
    do @(negedge clock); while (s_axi_bvalid !== 1'b1);
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axiRd(input logic [7:0] a, input logic [34:0] x);
    rdQ.push_back(x);
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(negedge clock); while (s_axi_arready !== 1'b1);
    @(posedge clock);
    s_axi_arvalid <= 1'b0;
    do @(negedge clock); while (s_axi_rvalid !== 1'b1);
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask

  // expected address formed here from the access, page and frame flag
  task automatic acc(input logic s, input logic f, input logic w, input logic [15:0] a);
    if (!a[15] || s || (f && frameOn)) memQ.push_back({w, 1'b0, 8'h00, a});
    else if (!pg[9]) memQ.push_back({w, 1'b0, pg[8:0], a[14:0]});
    else if (!w) memQ.push_back({2'b01, pg[8:0], a[14:0]});
    cpu.access(s, f, w, a);
  endtask

  task automatic stk(input int op, input logic [22:0] v, input pds_pkg::pds_pc_kind_t k, input logic [7:0] s);
    case (op)
      0: sp = {v[15:1], 1'b0};
      1: begin stkQ.push_back({1'b1, sp, v[15:0]}); sp += 16'h2; end
      2: begin sp -= 16'h2; stkQ.push_back({1'b0, sp, 16'h0}); end
      default: begin
        stkQ.push_back({1'b1, sp, v[15:0]});
        stkQ.push_back({1'b1, sp + 16'h2, k == pds_pkg::PC_EXC ? {s, 1'b0, v[22:16]} : {9'h0, v[22:16]}});
        sp += 16'h4;
      end
    endcase
    cpu.stack(op, v, k, s);
  endtask

  task automatic resetCheck;
    {sp, pg, frameOn} = {pds_pkg::SP_RESET, pds_pkg::PAGE_RESET, 1'b0};
    axiRd(pds_pkg::OFF_PAGE, ok(32'h001));
    axiRd(pds_pkg::OFF_SP, ok(32'h1000));
  endtask

  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    resetCheck;
    for (i = 8; i <= 16; i += 4) axiRd(i[7:0], ok(32'h0));
    axiRd(8'h14, {1'b0, pds_pkg::RESP_SLVERR, 32'h0});
    axiWr(8'h14, 32'h1, pds_pkg::RESP_SLVERR);
    axiWr(pds_pkg::OFF_PAGE, 32'h0, pds_pkg::RESP_OKAY);
    axiWr(pds_pkg::OFF_PAGE, 32'h400, pds_pkg::RESP_OKAY);
    axiRd(pds_pkg::OFF_PAGE, ok(32'h001));
    $display("test reset_values done");
    // both window limits, then random pages, frame flag alternating
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      pg = (i == 0) ? 10'h200 : (i == 1) ? 10'h3FF : {i < 6, r[8:0]};
      if (pg == 10'h0) pg = 10'h1;
      frameOn = i[0];
      axiWr(pds_pkg::OFF_PAGE, {22'h0, pg}, pds_pkg::RESP_OKAY);
      axiWr(pds_pkg::OFF_CTRL, {31'h0, frameOn}, pds_pkg::RESP_OKAY);
      for (j = 0; j < 6; j++) begin
        r = $random(seed);
        effAddr = r[15:0]; // data pages below 0x200 reached with bit15 set too
        acc(r[16], r[17], r[18], effAddr);
      end
    end
    axiRd(pds_pkg::OFF_STAT, {1'b0, pds_pkg::RESP_OKAY, 32'h0});
    $display("test paging done");
    // refused program space write raises unmasked event
    pg = 10'h2A5;
    axiWr(pds_pkg::OFF_PAGE, 32'h2A5, pds_pkg::RESP_OKAY);
    axiWr(pds_pkg::OFF_MASK, 32'h2, pds_pkg::RESP_OKAY);
    acc(1'b0, 1'b0, 1'b1, 16'h9234);
    for (i = 0; i < 8 && irq !== 1'b1; i++) @(negedge clock);
    check(irq, 1'b1, "irq set");
    axiRd(pds_pkg::OFF_STAT, ok(32'h2));
    repeat (3) @(negedge clock);
    check(irq, 1'b0, "irq cleared");
    axiWr(pds_pkg::OFF_MASK, 32'h0, pds_pkg::RESP_OKAY);
    acc(1'b0, 1'b0, 1'b1, 16'hC000);
    repeat (4) @(negedge clock);
    check(irq, 1'b0, "irq masked");
    axiRd(pds_pkg::OFF_STAT, ok(32'h2));
    // status already set when the mask opens must raise irq
    acc(1'b0, 1'b0, 1'b1, 16'hC000);
    axiWr(pds_pkg::OFF_MASK, 32'h2, pds_pkg::RESP_OKAY);
    @(negedge clock);
    check(irq, 1'b1, "irq on unmask");
    axiRd(pds_pkg::OFF_STAT, ok(32'h2));
    $display("test refused_write done");
    stk(3, 23'h5ABCDE, pds_pkg::PC_CALL, 8'hA7);
    stk(3, 23'h3F0123, pds_pkg::PC_EXC, 8'hC6);
    for (i = 0; i < 4; i++) stk(1, $random(seed), pds_pkg::PC_NONE, 8'h0);
    for (i = 0; i < 6; i++) stk(2, 23'h0, pds_pkg::PC_NONE, 8'h0);
    stk(0, 23'h2345, pds_pkg::PC_NONE, 8'h0);
    axiRd(pds_pkg::OFF_SP, ok(32'h2344));
    axiWr(pds_pkg::OFF_SP, 32'h3457, pds_pkg::RESP_OKAY);
    sp = 16'h3456;
    axiRd(pds_pkg::OFF_SP, ok(32'h3456));
    stk(1, 23'h0BEEF, pds_pkg::PC_NONE, 8'h0);
    $display("test stack done");
    // second reset must restore page and pointer
    axiWr(pds_pkg::OFF_PAGE, 32'h155, pds_pkg::RESP_OKAY);
    repeat (4) @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    resetCheck;
    $display("test second_reset done");
    check(35'(memQ.size() + stkQ.size() + rdQ.size() + bQ.size()), 35'h0, "left over");
    finish_test;
  end
endmodule
